// ---- logic/mie_alu.sv ----
// arithmetic and logic unit of the instruction executor
`timescale 1ns/1ps

module mie_alu
  import mie_pkg::*;
(
  // operation
  input  mie_func_t       func_i,
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  input  wire logic       carry_i,
  // result
  output logic      [7:0] res_o,
  output logic            zero_o,
  output logic            carry_o
);

  logic [8:0] sum9;

  always_comb
  begin
    sum9    = 9'h000;
    res_o   = a_i;
    carry_o = carry_i;
    unique case (func_i)
      F_ADD:
      begin
        sum9    = {1'b0, a_i} + {1'b0, b_i};
        res_o   = sum9[7:0];
        carry_o = sum9[8];
      end
      F_AND:
      begin
        res_o   = a_i & b_i;
        carry_o = 1'b0;
      end
      // compare yields the difference only to set the flags
      F_CP, F_SUB:
      begin
        sum9    = {1'b0, a_i} - {1'b0, b_i};
        res_o   = sum9[7:0];
        carry_o = sum9[8];
      end
      F_INC:   res_o = b_i + 8'h01;
      F_DEC:   res_o = b_i - 8'h01;
      F_CLR:
      begin
        res_o   = 8'h00;
        carry_o = 1'b0;
      end
      F_COM:
      begin
        res_o   = ~a_i;
        carry_o = a_i[7];
      end
      F_RLC:
      begin
        res_o   = {a_i[6:0], carry_i};
        carry_o = a_i[7];
      end
      F_SLA:
      begin
        res_o   = {a_i[6:0], 1'b0};
        carry_o = a_i[7];
      end
      default: res_o = a_i;
    endcase
    zero_o = (res_o == 8'h00);
  end

endmodule

// ---- logic/mie_core.sv ----
// instruction decode and execute core of the 8-bit controller
`timescale 1ns/1ps
`include "mie_defs.svh"

module mie_core
  import mie_pkg::*;
#(
  parameter int STACK_DEPTH = `MIE_STACK_DEPTH
)
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // program memory, read data valid in the cycle the address stands
  output logic      [11:0] pm_addr_o,
  input  wire logic [7:0]  pm_data_i,
  // data space, read data valid in the cycle the address stands
  output logic      [7:0]  ds_addr_o,
  output logic      [7:0]  ds_wdata_o,
  output logic             ds_we_o,
  input  wire logic [7:0]  ds_rdata_i,
  // option and wake pins
  input  wire logic        wdog_sel_i,
  input  wire logic        wake_i,
  // core state
  output logic      [7:0]  acc_o,
  output logic             zero_o,
  output logic             carry_o,
  output logic             stopped_o,
  output logic             waiting_o
);

  localparam int SPW = $clog2(STACK_DEPTH + 1);

  // ***********************************************************************
  // decode
  // ***********************************************************************
  logic [2:0]  step;
  logic [7:0]  ir;
  logic [7:0]  b2;
  logic [7:0]  b3;
  logic        tbit;
  logic [11:0] ipc;
  logic [7:0]  op;
  mie_cls_t    cls;
  mie_func_t   func;
  mie_inh_t    inh;
  logic [1:0]  nlen;
  logic [2:0]  ncyc;
  logic        last;
  logic        running;
  logic        mem_tgt;
  logic        ctrl_op;

  // the opcode is still on the bus during the first cycle
  assign op      = (step == 3'h0) ? pm_data_i : ir;
  assign inh     = mie_inh_t'(op[3:0]);
  assign running = !stopped_o && !waiting_o;
  assign ctrl_op = (cls == CLS_INH) && (op[3:0] <= INH_WAIT);

  always_comb
  begin
    cls = CLS_INH;
    if (!op[7])
      cls = CLS_SHORT;
    else
      unique case (op[6:5])
        2'b00: cls = op[4] ? CLS_JUMP : CLS_CALL;
        2'b01: cls = op[3] ? CLS_BITOP : CLS_BTEST;
        2'b10: cls = !op[0] ? CLS_IND : (op[4] ? CLS_IMM : CLS_DIR);
        2'b11: cls = CLS_INH;
      endcase
  end

  always_comb
  begin
    func = F_NONE;
    if (cls == CLS_IND || cls == CLS_DIR)
      func = mie_func_t'({1'b0, op[3:1]});
    else if (cls == CLS_IMM && op[3:1] < 3'h4)
      func = mie_func_t'({1'b0, op[3:1]});
    else if (cls == CLS_INH)
      unique case (inh)
        INH_COM:  func = F_COM;
        INH_RLC:  func = F_RLC;
        INH_SLA:  func = F_SLA;
        INH_CLRA: func = F_CLR;
        default:  func = F_NONE;
      endcase
  end

  assign mem_tgt = (cls == CLS_IND || cls == CLS_DIR)
                   && (func == F_INC || func == F_DEC || func == F_CLR);

  // lengths in bytes and in cycles
  always_comb
  begin
    nlen = 2'h1;
    unique case (cls)
      CLS_CALL, CLS_JUMP, CLS_BITOP, CLS_IMM: nlen = 2'h2;
      CLS_BTEST: nlen = 2'h3;
      CLS_DIR:   nlen = (func == F_CLR) ? 2'h3 : 2'h2;
      CLS_INH:   nlen = (inh == INH_SLA || inh == INH_CLRA) ? 2'h2 : 2'h1;
      default:   nlen = 2'h1;
    endcase
    if (cls == CLS_SHORT)
      ncyc = `MIE_CYC_SHORT;
    else if (cls == CLS_BTEST)
      ncyc = `MIE_CYC_BTEST;
    else if (ctrl_op)
      ncyc = `MIE_CYC_CTRL;
    else
      ncyc = `MIE_CYC_ALU;
  end

  assign last = (step == ncyc - 3'h1);

  // ***********************************************************************
  // arithmetic unit
  // ***********************************************************************
  logic [7:0] alu_res;
  logic       alu_zero;
  logic       alu_carry;

  mie_alu u_alu (
    .func_i  (func),
    .a_i     (acc_o),
    .b_i     ((cls == CLS_IMM) ? b2 : ds_rdata_i),
    .carry_i (carry_o),
    .res_o   (alu_res),
    .zero_o  (alu_zero),
    .carry_o (alu_carry)
  );

  // ***********************************************************************
  // next program counter and return stack
  // ***********************************************************************
  logic [13:0]    stk [STACK_DEPTH];
  logic [SPW-1:0] sp;
  logic [SPW-1:0] top_idx;
  logic [SPW-1:0] push_idx;
  logic [11:0]    short_tgt;
  logic [11:0]    btest_tgt;
  logic [11:0]    next_pc;
  logic           short_taken;

  assign top_idx  = (sp == '0) ? '0 : sp - SPW'(1);
  assign push_idx = (sp == SPW'(STACK_DEPTH)) ? SPW'(STACK_DEPTH - 1) : sp;
  assign short_tgt = ipc + `MIE_SHORT_BIAS
                     + {{7{op[6]}}, op[6:2]};
  assign btest_tgt = ipc + `MIE_BTEST_BIAS
                     + {{4{b3[7]}}, b3};

  always_comb
  begin
    unique case (mie_cond_t'(op[1:0]))
      COND_ZERO_CLEAR:  short_taken = !zero_o;
      COND_CARRY_CLEAR: short_taken = !carry_o;
      COND_ZERO_SET:    short_taken = zero_o;
      COND_CARRY_SET:   short_taken = carry_o;
    endcase
  end

  always_comb
  begin
    next_pc = ipc + {10'h000, nlen};
    if (cls == CLS_SHORT && short_taken)
      next_pc = short_tgt;
    else if (cls == CLS_CALL || cls == CLS_JUMP)
      next_pc = {op[3:0], b2};
    else if (cls == CLS_BTEST && tbit == op[4])
      next_pc = btest_tgt;
    else if (cls == CLS_INH && (inh == INH_RET || inh == INH_RETURN_FROM_INTERRUPT))
      next_pc = stk[top_idx][11:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      sp <= '0;
    else if (running && last && cls == CLS_CALL && sp != SPW'(STACK_DEPTH))
      sp <= sp + SPW'(1);
    else if (running && last && cls == CLS_INH
             && (inh == INH_RET || inh == INH_RETURN_FROM_INTERRUPT) && sp != '0)
      sp <= sp - SPW'(1);
  end

  // flags travel with the return address so that return_from_interrupt can restore them
  always_ff @(posedge clk_i)
  begin
    if (running && last && cls == CLS_CALL)
      stk[push_idx] <= {zero_o, carry_o, ipc + {10'h000, nlen}};
  end

  // ***********************************************************************
  // sequencing and operand capture
  // ***********************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      step      <= 3'h0;
      ir        <= 8'h00;
      ipc       <= `MIE_RESET_PC;
      pm_addr_o <= `MIE_RESET_PC;
    end
    else if (running)
    begin
      if (step == 3'h0)
        ir <= pm_data_i;
      if (last)
      begin
        step      <= 3'h0;
        ipc       <= next_pc;
        pm_addr_o <= next_pc;
      end
      else
      begin
        step <= step + 3'h1;
        if ((step + 3'h1) < {1'b0, nlen})
          pm_addr_o <= pm_addr_o + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      b2   <= 8'h00;
      b3   <= 8'h00;
      tbit <= 1'b0;
    end
    else if (running && step == 3'h1)
      b2 <= pm_data_i;
    else if (running && step == 3'h2)
    begin
      b3   <= pm_data_i;
      tbit <= ds_rdata_i[op[2:0]];
    end
  end

  // ***********************************************************************
  // accumulator and flags
  // ***********************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      acc_o   <= 8'h00;
      zero_o  <= 1'b0;
      carry_o <= 1'b0;
    end
    else if (running && step == 3'h2 && cls == CLS_BTEST)
      carry_o <= ds_rdata_i[op[2:0]];
    else if (running && step == 3'h2 && func != F_NONE && !ctrl_op)
    begin
      if (!mem_tgt && func != F_CP)
        acc_o <= alu_res;
      if (func == F_INC || func == F_DEC)
        zero_o <= alu_zero;
      else if (!mem_tgt)
      begin
        zero_o  <= alu_zero;
        carry_o <= alu_carry;
      end
    end
    else if (running && last && cls == CLS_INH && inh == INH_RETURN_FROM_INTERRUPT)
      {zero_o, carry_o} <= stk[top_idx][13:12];
  end

  // ***********************************************************************
  // data space access
  // ***********************************************************************
  logic [7:0] bit_mask;

  assign bit_mask = 8'h01 << op[2:0];

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      ds_addr_o  <= 8'h00;
      ds_wdata_o <= 8'h00;
      ds_we_o    <= 1'b0;
    end
    else if (running)
    begin
      ds_we_o <= 1'b0;
      if (step == 3'h0 && cls == CLS_IND)
        ds_addr_o <= `MIE_PTR_BASE
                     | {7'h00, op[`MIE_PTR_SEL_BIT]};
      else if (step == 3'h1 && cls == CLS_IND)
        ds_addr_o <= ds_rdata_i;
      else if (step == 3'h1 && (cls == CLS_DIR || cls == CLS_BTEST
                                || cls == CLS_BITOP))
        ds_addr_o <= pm_data_i;
      else if (step == 3'h2 && mem_tgt)
      begin
        ds_we_o    <= 1'b1;
        ds_wdata_o <= alu_res;
      end
      else if (step == 3'h2 && cls == CLS_BITOP)
      begin
        ds_we_o    <= 1'b1;
        ds_wdata_o <= op[4] ? (ds_rdata_i | bit_mask)
                            : (ds_rdata_i & ~bit_mask);
      end
    end
  end

  // ***********************************************************************
  // stop and wait
  // ***********************************************************************
  logic wake_m;
  logic wake_s;
  logic wdog_m;
  logic wdog_s;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      wake_m <= 1'b0;
      wake_s <= 1'b0;
    end
    else
    begin
      wake_m <= wake_i;
      wake_s <= wake_m;
    end
  end

  // the option is static, so it keeps sampling through reset: a stop
  // straight after release must already see it
  always_ff @(posedge clk_i)
  begin
    wdog_m <= wdog_sel_i;
    wdog_s <= wdog_m;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      stopped_o <= 1'b0;
      waiting_o <= 1'b0;
    end
    else if (running && last && cls == CLS_INH && inh == INH_STOP)
    begin
      // a running watchdog must not be frozen by stop
      stopped_o <= !wdog_s;
      waiting_o <= wdog_s;
    end
    else if (running && last && cls == CLS_INH && inh == INH_WAIT)
      waiting_o <= 1'b1;
    else if (!running && wake_s)
    begin
      stopped_o <= 1'b0;
      waiting_o <= 1'b0;
    end
  end

  // ***********************************************************************
  // checks
  // ***********************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_four_steps;
    step == 3'h1 ##1 step == 3'h2 ##1 step == 3'h3 ##1 step == 3'h0;
  endsequence

  sequence s_five_steps;
    step == 3'h1 ##1 step == 3'h2 ##1 step == 3'h3 ##1 step == 3'h4
    ##1 step == 3'h0;
  endsequence

  chk_alu_cycles: assert property (
    running && step == 3'h0 && (cls == CLS_IND || cls == CLS_DIR
                                || cls == CLS_IMM) |=> s_four_steps)
    else $error("arithmetic instruction not four cycles");

  chk_btest_cycles: assert property (
    running && step == 3'h0 && cls == CLS_BTEST |=> s_five_steps)
    else $error("bit-test branch not five cycles");

  chk_btest_carry: assert property (
    running && step == 3'h2 && cls == CLS_BTEST
    |=> carry_o == $past(ds_rdata_i[ir[2:0]]) && $stable(zero_o))
    else $error("tested bit not copied to carry");

  chk_short_flags: assert property (
    running && step == 3'h0 && cls == CLS_SHORT
    |=> $stable(zero_o) && $stable(carry_o)
    ##1 step == 3'h0 && $stable(zero_o) && $stable(carry_o))
    else $error("short branch changed flags or length");

  chk_short_target: assert property (
    running && step == 3'h1 && cls == CLS_SHORT && short_taken
    |=> pm_addr_o == $past(ipc) + 12'h001
        + {{7{$past(ir[6])}}, $past(ir[6:2])})
    else $error("short branch target wrong");

  chk_jump_target: assert property (
    running && step == 3'h3 && (cls == CLS_CALL || cls == CLS_JUMP)
    |=> pm_addr_o == {$past(ir[3:0]), $past(b2)} && $stable(carry_o))
    else $error("long jump target wrong");

  chk_incdec_carry: assert property (
    running && step == 3'h2 && (cls == CLS_IND || cls == CLS_DIR)
    && (func == F_INC || func == F_DEC)
    |=> $stable(carry_o) && ds_we_o ##1 !ds_we_o)
    else $error("increment or decrement touched carry");

  chk_shift_carry: assert property (
    running && step == 3'h2 && cls == CLS_INH
    && (func == F_RLC || func == F_SLA)
    |=> carry_o == $past(acc_o[7]) && zero_o == (acc_o == 8'h00))
    else $error("shift carry or zero wrong");

  chk_acc_add: assert property (
    running && step == 3'h2 && cls == CLS_IMM && func == F_ADD
    |=> acc_o == 8'($past(acc_o) + $past(b2)))
    else $error("immediate add result wrong");

  chk_bit_write: assert property (
    running && step == 3'h2 && cls == CLS_BITOP
    |=> ds_we_o && ds_wdata_o[$past(ir[2:0])] == $past(ir[4])
        && $stable(zero_o) && $stable(carry_o))
    else $error("bit set or clear wrong");

  chk_stop_wdog: assert property (
    running && step == 3'h1 && cls == CLS_INH && inh == INH_STOP && wdog_s
    |=> waiting_o && !stopped_o)
    else $error("stop not turned into wait");

  chk_ind_ptr: assert property (
    running && step == 3'h0 && cls == CLS_IND
    |=> ds_addr_o == (8'h80 | {7'h00, $past(pm_data_i[4])}))
    else $error("indirect pointer address wrong");

endmodule

// ---- logic/mie_defs.svh ----
// timing counts, addresses and field positions of the instruction executor
`ifndef MIE_DEFS_SVH
`define MIE_DEFS_SVH

// ***********************************************************************
// data space
// ***********************************************************************
`define MIE_PTR_BASE     8'h80
`define MIE_PTR_SEL_BIT  4

// ***********************************************************************
// cycle counts per instruction group
// ***********************************************************************
`define MIE_CYC_ALU      3'h4
`define MIE_CYC_CTRL     3'h2
`define MIE_CYC_SHORT    3'h2
`define MIE_CYC_BTEST    3'h5

// ***********************************************************************
// program counter
// ***********************************************************************
`define MIE_RESET_PC     12'h000
`define MIE_SHORT_BIAS   12'h001
`define MIE_BTEST_BIAS   12'h002
`define MIE_STACK_DEPTH  6

`endif

// ---- logic/mie_pkg.sv ----
// types shared by the instruction executor and its arithmetic unit
package mie_pkg;

  // ***********************************************************************
  // instruction classes
  // ***********************************************************************
  typedef enum {
    CLS_SHORT, CLS_CALL, CLS_JUMP, CLS_BTEST, CLS_BITOP,
    CLS_IND, CLS_DIR, CLS_IMM, CLS_INH
  } mie_cls_t;

  // ***********************************************************************
  // arithmetic functions, low codes match the opcode operation field
  // ***********************************************************************
  typedef enum logic [3:0] {
    F_ADD = 4'h0, F_AND, F_CP, F_SUB, F_INC, F_DEC, F_CLR, F_NONE,
    F_COM, F_RLC, F_SLA
  } mie_func_t;

  // ***********************************************************************
  // inherent operations, codes are the low opcode nibble
  // ***********************************************************************
  typedef enum logic [3:0] {
    INH_NOP = 4'h0, INH_RET, INH_RETURN_FROM_INTERRUPT, INH_STOP, INH_WAIT,
    INH_COM, INH_RLC, INH_SLA, INH_CLRA
  } mie_inh_t;

  // branch conditions of the one-byte relative branch
  typedef enum logic [1:0] {
    COND_ZERO_CLEAR = 2'h0, COND_CARRY_CLEAR, COND_ZERO_SET, COND_CARRY_SET
  } mie_cond_t;

endpackage

// ---- test/mie_core_tb.sv ----
// self-checking bench for the instruction executor
`timescale 1ns/1ps

module mie_core_tb;
  logic        clk_i      = 1'b0;
  logic        rstn_i     = 1'b0;
  logic        wdog_sel_i = 1'b0;
  logic        wake_i     = 1'b0;
  logic [11:0] pm_addr_o;
  logic [7:0]  pm_data_i;
  logic [7:0]  ds_addr_o;
  logic [7:0]  ds_wdata_o;
  logic        ds_we_o;
  logic [7:0]  ds_rdata_i;
  logic [7:0]  acc_o;
  logic        zero_o;
  logic        carry_o;
  logic        stopped_o;
  logic        waiting_o;
  int          failures  = 0;
  int          tests_run = 0;
  int          base;
  int          cyc;

  always #5 clk_i = ~clk_i;

  mie_core u_mie_core (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .pm_addr_o  (pm_addr_o),
    .pm_data_i  (pm_data_i),
    .ds_addr_o  (ds_addr_o),
    .ds_wdata_o (ds_wdata_o),
    .ds_we_o    (ds_we_o),
    .ds_rdata_i (ds_rdata_i),
    .wdog_sel_i (wdog_sel_i),
    .wake_i     (wake_i),
    .acc_o      (acc_o),
    .zero_o     (zero_o),
    .carry_o    (carry_o),
    .stopped_o  (stopped_o),
    .waiting_o  (waiting_o)
  );

  mie_mem u_mie_mem (
    .clk_i      (clk_i),
    .pm_addr_i  (pm_addr_o),
    .pm_data_o  (pm_data_i),
    .ds_addr_i  (ds_addr_o),
    .ds_wdata_i (ds_wdata_o),
    .ds_we_i    (ds_we_o),
    .ds_rdata_o (ds_rdata_i)
  );

  task automatic wrap_up();
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // unused program bytes hold a wait, so a stray fetch ends in waiting_o
  task automatic prep(input logic [7:0] code[$]);
    for (int i = 0; i < 4096; i++)
      u_mie_mem.pm[i] = 8'he4;
    for (int i = 0; i < 256; i++)
      u_mie_mem.ds[i] = 8'h00;
    foreach (code[i])
      u_mie_mem.pm[i] = code[i];
  endtask

  task automatic put(input logic [11:0] a, input logic [7:0] code[$]);
    foreach (code[i])
      u_mie_mem.pm[a + 12'(i)] = code[i];
  endtask

  // cycles are counted from reset release until the core parks itself
  task automatic run(input logic wd);
    cyc = 0;
    wdog_sel_i = wd;
    rstn_i = 1'b0;
    repeat (4) @(negedge clk_i);
    rstn_i = 1'b1;
    while (!(stopped_o === 1'b1 || waiting_o === 1'b1))
    begin
      @(negedge clk_i);
      cyc++;
      if (cyc > 300)
      begin
        failures++;
        wrap_up();
      end
    end
  endtask

  task automatic state(input logic [7:0] a, input logic [1:0] zc);
    chk(acc_o, a);
    chk({6'h0, zero_o, carry_o}, {6'h0, zc});
    chk({6'h0, stopped_o, waiting_o}, 8'h02);
  endtask

  // nop, add, sub, rotate, add direct with wrap to zero
  task automatic t_arith();
    prep({8'he0, 8'hd1, 8'h05, 8'hd7, 8'h07, 8'he6, 8'hc1, 8'h40, 8'he3});
    u_mie_mem.ds[8'h40] = 8'h03;
    run(1'b0);
    state(8'h00, 2'h3);
    chk(8'(cyc - base), 8'h12);
  endtask

  // pointer select, inc/dec in memory, and, compare, clear of a location
  task automatic t_mem();
    prep({8'hd1, 8'h01, 8'hc8, 8'hda, 8'hd2, 8'hd5, 8'h02,
          8'hcd, 8'h50, 8'h00, 8'he3});
    u_mie_mem.ds[8'h80] = 8'h20;
    u_mie_mem.ds[8'h81] = 8'h30;
    u_mie_mem.ds[8'h20] = 8'hff;
    u_mie_mem.ds[8'h30] = 8'h02;
    u_mie_mem.ds[8'h50] = 8'haa;
    run(1'b0);
    state(8'h01, 2'h1);
    chk(u_mie_mem.ds[8'h20], 8'h00);
    chk(u_mie_mem.ds[8'h30], 8'h01);
    chk(u_mie_mem.ds[8'h50], 8'h00);
    chk(8'(cyc - base), 8'h18);
  endtask

  // clear A, complement, shift, decrement keeps carry
  task automatic t_acc();
    prep({8'he8, 8'h00, 8'he5, 8'he7, 8'h00, 8'hcb, 8'h60, 8'he3});
    u_mie_mem.ds[8'h60] = 8'h01;
    run(1'b0);
    state(8'hfe, 2'h3);
    chk(u_mie_mem.ds[8'h60], 8'h00);
    chk(8'(cyc - base), 8'h10);
  endtask

  // all four conditions, both range ends, taken and not taken
  task automatic t_branch();
    prep({8'hd5, 8'h01, 8'h15, 8'h3f, 8'h0e, 8'he3});
    put(12'h013, {8'h40});
    run(1'b0);
    state(8'h00, 2'h1);
    chk(8'(cyc - base), 8'h0c);
  endtask

  // bit set/clear, bit-test both ways at the range ends, call, jump, return_from_interrupt
  task automatic t_bits();
    prep({8'hb8, 8'h70, 8'haa, 8'h70, 8'hb0, 8'h70, 8'h7f,
          8'h81, 8'h23, 8'he3});
    put(12'h085, {8'ha1, 8'h70, 8'h80});
    put(12'h123, {8'hd5, 8'h01, 8'h93, 8'h00});
    put(12'h300, {8'he2});
    u_mie_mem.ds[8'h70] = 8'h04;
    run(1'b0);
    state(8'h00, 2'h0);
    chk(u_mie_mem.ds[8'h70], 8'h01);
    chk(8'(cyc - base), 8'h20);
  endtask

  // stop becomes wait under the watchdog option; wake releases it
  task automatic t_ctrl();
    int n;
    n = 0;
    prep({8'he4});
    run(1'b0);
    chk({6'h0, stopped_o, waiting_o}, 8'h01);
    chk(8'(cyc - base), 8'h00);
    prep({8'he3, 8'he3});
    run(1'b1);
    chk({6'h0, stopped_o, waiting_o}, 8'h01);
    chk(8'(cyc - base), 8'h00);
    wake_i = 1'b1;
    while (waiting_o === 1'b1 && n < 6)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(8'(n), 8'h03);
    wake_i = 1'b0;
  endtask

  initial
  begin
    prep({8'he3});
    run(1'b0);
    base = cyc;
    chk({6'h0, stopped_o, waiting_o}, 8'h02);
    t_arith();
    t_mem();
    t_acc();
    t_branch();
    t_bits();
    t_ctrl();
    wrap_up();
  end
endmodule

// ---- test/mie_mem.sv ----
// program memory and data space model facing the core
`timescale 1ns/1ps

module mie_mem
(
  // clock
  input  wire logic        clk_i,
  // program side
  input  wire logic [11:0] pm_addr_i,
  output logic      [7:0]  pm_data_o,
  // data side
  input  wire logic [7:0]  ds_addr_i,
  input  wire logic [7:0]  ds_wdata_i,
  input  wire logic        ds_we_i,
  output logic      [7:0]  ds_rdata_o
);
  logic [7:0] pm [4096];
  logic [7:0] ds [256];

  // both reads answer in the cycle the address stands
  assign pm_data_o  = pm[pm_addr_i];
  assign ds_rdata_o = ds[ds_addr_i];

  // plain always: the bench also preloads this array between runs
  always @(posedge clk_i)
  begin
    if (ds_we_i)
      ds[ds_addr_i] <= ds_wdata_i;
  end
endmodule
